/* File: hw/dfl_bit_manipulation_engine.sv */
`timescale 1ns/1ns
module dfl_bit_manipulation_engine
	import dfl_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        nrst,
	// Core side
	input  wire logic [31:0] m_haddr,
	input  wire logic [1:0]  m_htrans,
	input  wire logic        m_hwrite,
	input  wire logic [2:0]  m_hsize,
	input  wire logic [31:0] m_hwdata,
	output logic      [31:0] m_hrdata,
	output logic             m_hready,
	output logic             m_hresp,
	// Peripheral side
	output logic      [31:0] s_haddr,
	output logic      [1:0]  s_htrans,
	output logic             s_hwrite,
	output logic      [2:0]  s_hsize,
	output logic      [31:0] s_hwdata,
	input  wire logic [31:0] s_hrdata,
	input  wire logic        slave_port_ready,
	input  wire logic        s_hresp,
	// Control registers
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest
);

	// ====================================================================
	// Helpers
	function automatic logic [31:0] cont_mask(input logic [2:0] sz);
		case (sz)
			HSIZE_BYTE: cont_mask = 32'h0000_00ff;
			HSIZE_HALF: cont_mask = 32'h0000_ffff;
			default:    cont_mask = 32'hffff_ffff;
		endcase
	endfunction

	// Field of wm1+1 bits at lsb, clipped to the container
	function automatic logic [31:0] field_mask(input logic [4:0] lsb,
			input logic [3:0] wm1, input logic [2:0] sz);
		logic [31:0] ones;
		ones = (32'h1 << ({1'h0, wm1} + 5'h1)) - 32'h1;
		field_mask = (ones << lsb) & cont_mask(sz);
	endfunction

	// Move the addressed lane of read data down to bit 0
	function automatic logic [31:0] lane_down(input logic [31:0] d,
			input logic [1:0] a, input logic [2:0] sz);
		logic [4:0] sh;
		sh = 5'h0;
		case (sz)
			HSIZE_BYTE: sh = {a, 3'h0};
			HSIZE_HALF: sh = {a[1], 4'h0};
			default:    sh = 5'h0;
		endcase
		lane_down = (d >> sh) & cont_mask(sz);
	endfunction

	// Copy a narrow container onto every lane for the write
	function automatic logic [31:0] lane_rep(input logic [31:0] d,
			input logic [2:0] sz);
		case (sz)
			HSIZE_BYTE: lane_rep = {4{d[7:0]}};
			HSIZE_HALF: lane_rep = {2{d[15:0]}};
			default:    lane_rep = d;
		endcase
	endfunction

	function automatic dfl_op_e decode_op(input logic [31:0] a,
			input logic wr);
		decode_op = OP_PLAIN;
		if (a[REGION_HI:REGION_LO] == REGION_VAL &&
				a[OP_HI:OP_LO] != OP_NONE) begin
			if (a[FIELD_OP_BIT])
				decode_op = wr ? OP_FIELD_INSERT : OP_FIELD_EXTRACT;
			else if (!wr && a[OP_HI:OP_LO] == OP_CLEAR_CODE)
				decode_op = OP_LOAD_CLEAR;
			else if (!wr && a[OP_HI:OP_LO] == OP_SET_CODE)
				decode_op = OP_LOAD_SET;
		end
	endfunction

	// Decoration bits are dropped; field ops lose bit 19 to the width
	function automatic logic [31:0] target_addr(input logic [31:0] a,
			input dfl_op_e op);
		if (op == OP_FIELD_INSERT || op == OP_FIELD_EXTRACT)
			target_addr = PERIPH_BASE + {13'h0, a[FLD_OFS_HI:0]};
		else
			target_addr = PERIPH_BASE + {12'h0, a[BIT_OFS_HI:0]};
	endfunction

	// ====================================================================
	// Request decode
	dfl_state_e  state_q;
	dfl_op_e     op_q;
	logic        en_q;
	logic [31:0] addr_q;
	logic [2:0]  size_q;
	logic [4:0]  lsb_q;
	logic [3:0]  wm1_q;
	logic [4:0]  bitpos_q;
	logic        bit_q;
	logic [31:0] data_q;
	logic [31:0] count_q;
	logic        rd_ack_q;

	dfl_op_e     cur_op;
	logic        accept;
	logic        decorated;
	logic [31:0] rd_cont;
	logic [31:0] fmask;
	logic [31:0] bmask;

	always_comb begin
		cur_op = en_q ? decode_op(m_haddr, m_hwrite) : OP_PLAIN;
	end

	// Core address phase is taken whenever the core sees ready
	assign accept    = m_htrans[1] && m_hready;
	assign decorated = accept && cur_op != OP_PLAIN;

	assign rd_cont = lane_down(s_hrdata, addr_q[1:0], size_q);
	assign fmask   = field_mask(lsb_q, wm1_q, size_q);
	assign bmask   = (32'h1 << bitpos_q) & cont_mask(size_q);

	// ====================================================================
	// Sequencer
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_PASS;
		end else begin
			case (state_q)
				ST_PASS, ST_DP2: begin
					if (slave_port_ready) begin
						state_q <= decorated ? ST_DP1 : ST_PASS;
					end
				end
				ST_DP1: begin
					// Each slave wait cycle holds the core one more cycle
					if (slave_port_ready) begin
						state_q <= ST_DP2;
					end
				end
				default: state_q <= ST_PASS;
			endcase
		end
	end

	// Capture of the decorated request in its first address phase
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			op_q     <= OP_PLAIN;
			addr_q   <= 32'h0;
			size_q   <= HSIZE_WORD;
			lsb_q    <= 5'h0;
			wm1_q    <= 4'h0;
			bitpos_q <= 5'h0;
		end else if (decorated) begin
			op_q     <= cur_op;
			addr_q   <= target_addr(m_haddr, cur_op);
			size_q   <= m_hsize;
			lsb_q    <= m_haddr[FLD_LSB_HI:FLD_LSB_LO];
			wm1_q    <= m_haddr[FLD_WM1_HI:FLD_WM1_LO];
			bitpos_q <= m_haddr[BIT_POS_HI:BIT_POS_LO];
		end
	end

	// Read-modify in the first data phase
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			data_q <= 32'h0;
			bit_q  <= 1'h0;
		end else if (state_q == ST_DP1 && slave_port_ready) begin
			case (op_q)
				OP_FIELD_INSERT: begin
					// Operand sits at its field position; lanes replicated by core
					data_q <= lane_rep((fmask & m_hwdata) |
						(~fmask & rd_cont), size_q);
				end
				OP_LOAD_SET: begin
					bit_q  <= rd_cont[bitpos_q];
					data_q <= lane_rep(rd_cont | bmask, size_q);
				end
				OP_LOAD_CLEAR: begin
					bit_q  <= rd_cont[bitpos_q];
					data_q <= lane_rep(rd_cont & ~bmask, size_q);
				end
				OP_FIELD_EXTRACT: begin
					data_q <= rd_cont & fmask;
				end
				default: data_q <= data_q;
			endcase
		end
	end

	// ====================================================================
	// Slave address phase
	always_comb begin
		s_haddr  = m_haddr;
		s_htrans = m_htrans;
		s_hwrite = m_hwrite;
		s_hsize  = m_hsize;
		if (state_q == ST_DP1) begin
			s_haddr = addr_q;
			s_hsize = size_q;
			if (op_q == OP_FIELD_EXTRACT) begin
				s_htrans = HTRANS_IDLE;
				s_hwrite = 1'h0;
			end else begin
				s_htrans = HTRANS_NONSEQ;
				s_hwrite = 1'h1;
			end
		end else if (cur_op != OP_PLAIN) begin
			s_haddr = target_addr(m_haddr, cur_op);
			// A decorated store starts as a read of the old value
			s_hwrite = 1'h0;
		end
	end

	// ====================================================================
	// Data phases
	always_comb begin
		s_hwdata = m_hwdata;
		m_hrdata = s_hrdata;
		if (state_q == ST_DP2) begin
			case (op_q)
				OP_FIELD_INSERT: s_hwdata = data_q;
				OP_LOAD_SET, OP_LOAD_CLEAR: begin
					s_hwdata = data_q;
					m_hrdata = {31'h0, bit_q};
				end
				OP_FIELD_EXTRACT: m_hrdata = data_q >> lsb_q;
				default: m_hrdata = s_hrdata;
			endcase
		end
	end

	// The core stays stalled through the first data phase
	assign m_hready = (state_q == ST_DP1) ? 1'h0 : slave_port_ready;
	assign m_hresp  = s_hresp;

	// ====================================================================
	// Control registers
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			en_q <= CTRL_EN_RST;
		end else if (avs_write && avs_address == REG_CTRL &&
				avs_byteenable[0]) begin
			en_q <= avs_writedata[CTRL_EN_BIT];
		end
	end

	// Count of decorated requests; a new one in the cycle of a clear leaves 1
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			count_q <= COUNT_RST;
		end else if (decorated && slave_port_ready) begin
			if (avs_write && avs_address == REG_COUNT)
				count_q <= 32'h1;
			else
				count_q <= count_q + 32'h1;
		end else if (avs_write && avs_address == REG_COUNT) begin
			count_q <= COUNT_RST;
		end
	end

	// Reads answer one cycle late so read data come from a register
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rd_ack_q     <= 1'h0;
			avs_readdata <= 32'h0;
		end else begin
			rd_ack_q <= avs_read && !rd_ack_q;
			if (avs_read && !rd_ack_q) begin
				case (avs_address)
					REG_CTRL:   avs_readdata <= {31'h0, en_q};
					REG_STATUS: avs_readdata <= {27'h0, op_q,
						state_q != ST_PASS, state_q == ST_DP1};
					REG_COUNT:  avs_readdata <= count_q;
					default:    avs_readdata <= 32'h0;
				endcase
			end
		end
	end

	assign avs_waitrequest = avs_read && !rd_ack_q;

endmodule

/* File: include/dfl_pkg.sv */
package dfl_pkg;

	// ====================================================================
	// Bus encodings
	localparam logic [1:0]  HTRANS_IDLE   = 2'h0;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0]  HSIZE_BYTE    = 3'h0;
	localparam logic [2:0]  HSIZE_HALF    = 3'h1;
	localparam logic [2:0]  HSIZE_WORD    = 3'h2;

	// ====================================================================
	// Decorated address layout
	localparam logic [31:0] PERIPH_BASE   = 32'h4000_0000;
	localparam int          REGION_HI     = 31;
	localparam int          REGION_LO     = 29;
	localparam logic [2:0]  REGION_VAL    = 3'h2;
	localparam int          OP_HI         = 28;
	localparam int          OP_LO         = 26;
	localparam int          FIELD_OP_BIT  = 28;
	localparam logic [2:0]  OP_NONE       = 3'h0;
	localparam logic [2:0]  OP_CLEAR_CODE = 3'h2;
	localparam logic [2:0]  OP_SET_CODE   = 3'h3;
	localparam int          FLD_LSB_HI    = 27;
	localparam int          FLD_LSB_LO    = 23;
	localparam int          FLD_WM1_HI    = 22;
	localparam int          FLD_WM1_LO    = 19;
	localparam int          BIT_POS_HI    = 25;
	localparam int          BIT_POS_LO    = 21;
	localparam int          FLD_OFS_HI    = 18;
	localparam int          BIT_OFS_HI    = 19;

	// ====================================================================
	// Control and status registers (byte offsets)
	localparam logic [3:0]  REG_CTRL      = 4'h0;
	localparam logic [3:0]  REG_STATUS    = 4'h4;
	localparam logic [3:0]  REG_COUNT     = 4'h8;
	localparam int          CTRL_EN_BIT   = 0;
	localparam logic        CTRL_EN_RST   = 1'h1;
	localparam logic [31:0] COUNT_RST     = 32'h0;

	typedef enum logic [2:0] {
		OP_PLAIN,
		OP_FIELD_INSERT,
		OP_FIELD_EXTRACT,
		OP_LOAD_SET,
		OP_LOAD_CLEAR
	} dfl_op_e;

	typedef enum logic [1:0] {
		ST_PASS,
		ST_DP1,
		ST_DP2
	} dfl_state_e;

endpackage

/* File: tb/dfl_assertions.sv */
`timescale 1ns/1ns
module dfl_assertions
	import dfl_pkg::*;
(
	input wire logic        clock,
	input wire logic        nrst,
	input wire logic [31:0] m_haddr,
	input wire logic [1:0]  m_htrans,
	input wire logic        m_hwrite,
	input wire logic [31:0] m_hrdata,
	input wire logic        m_hready,
	input wire logic        m_hresp,
	input wire logic [31:0] s_haddr,
	input wire logic [1:0]  s_htrans,
	input wire logic        s_hwrite,
	input wire logic        slave_port_ready,
	input wire logic        s_hresp,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable
);
	logic en_q;
	logic dec;
	logic ins;
	logic ext;
	logic bop;
	// ========
	// Decode mirror; enable tracked so plain mode is not misjudged
	assign dec = m_htrans[1] && m_hready && en_q &&
		m_haddr[REGION_HI:REGION_LO] == REGION_VAL &&
		m_haddr[OP_HI:OP_LO] != OP_NONE;
	assign ins = dec && m_hwrite && m_haddr[FIELD_OP_BIT];
	assign ext = dec && !m_hwrite && m_haddr[FIELD_OP_BIT];
	assign bop = dec && !m_hwrite &&
		m_haddr[OP_HI:OP_LO] inside {OP_SET_CODE, OP_CLEAR_CODE};
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			en_q <= CTRL_EN_RST;
		else if (avs_write && avs_address == REG_CTRL && avs_byteenable[0])
			en_q <= avs_writedata[CTRL_EN_BIT];
	end
	// ========
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	wait_pass_a: assert property (!slave_port_ready |-> !m_hready)
		else $error("core ready while slave waits");
	resp_pass_a: assert property (m_hresp == s_hresp)
		else $error("response not passed through");
	ins_read_a: assert property (ins |-> !s_hwrite &&
		s_haddr == PERIPH_BASE + m_haddr[FLD_OFS_HI:0])
		else $error("insert first phase wrong");
	ins_write_a: assert property (ins |=> s_hwrite && !m_hready &&
		s_htrans == HTRANS_NONSEQ && s_haddr == $past(s_haddr))
		else $error("insert write phase wrong");
	bit_write_a: assert property (bop |-> !s_hwrite &&
		s_haddr == PERIPH_BASE + m_haddr[BIT_OFS_HI:0]
		##1 s_hwrite && s_haddr == $past(s_haddr))
		else $error("bit load sequence wrong");
	ext_idle_a: assert property (ext |-> !s_hwrite ##1
		s_htrans == HTRANS_IDLE && !m_hready)
		else $error("extract second phase not idle");
	bit_ret_a: assert property (bop ##1 slave_port_ready
		##1 slave_port_ready |-> m_hready && m_hrdata[31:1] == 31'h0)
		else $error("bit return not right-justified");
	ext_ret_a: assert property (ext ##1 slave_port_ready
		##1 slave_port_ready |-> m_hready && m_hrdata[31:16] == 16'h0)
		else $error("extract return not aligned");
	cover property (ins);
	cover property (bop ##1 !slave_port_ready);
	cover property (ext);
endmodule

bind dfl_bit_manipulation_engine dfl_assertions chk_u (.clock, .nrst,
	.m_haddr, .m_htrans, .m_hwrite, .m_hrdata, .m_hready, .m_hresp,
	.s_haddr, .s_htrans, .s_hwrite, .slave_port_ready, .s_hresp,
	.avs_address, .avs_write, .avs_writedata, .avs_byteenable);

/* File: tb/dfl_slave_model.sv */
`timescale 1ns/1ns
module dfl_slave_model
	import dfl_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        slow,
	input  wire logic [31:0] s_haddr,
	input  wire logic [1:0]  s_htrans,
	input  wire logic        s_hwrite,
	input  wire logic [2:0]  s_hsize,
	input  wire logic [31:0] s_hwdata,
	output logic      [31:0] s_hrdata,
	output logic             slave_port_ready,
	output logic             s_hresp
);
	logic [31:0] mem [16];
	logic [3:0]  a_q;
	logic [1:0]  ln_q;
	logic        dp_q;
	logic        wr_q;
	logic [2:0]  sz_q;
	logic        w_q;
	// ========
	// One wait per data phase when slow stretches every step
	assign slave_port_ready = !(dp_q && slow && !w_q);
	assign s_hresp = 1'b0;
	// Outside a read data phase the bus shows garbage, not stale data
	assign s_hrdata = (dp_q && !wr_q) ? mem[a_q] : ~mem[a_q];
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			dp_q <= 1'b0;
			w_q <= 1'b0;
		end else begin
			w_q <= dp_q && slow && !w_q;
			if (slave_port_ready) begin
				dp_q <= s_htrans[1];
				wr_q <= s_hwrite;
				sz_q <= s_hsize;
				a_q <= s_haddr[5:2];
				ln_q <= s_haddr[1:0];
			end
		end
	end
	always_ff @(posedge clock) begin
		// Narrow writes touch only their own lanes, as a real slave would
		if (dp_q && wr_q && slave_port_ready && sz_q == HSIZE_BYTE)
			mem[a_q][ln_q*8 +: 8] <= s_hwdata[ln_q*8 +: 8];
		else if (dp_q && wr_q && slave_port_ready && sz_q == HSIZE_HALF)
			mem[a_q][ln_q[1]*16 +: 16] <= s_hwdata[ln_q[1]*16 +: 16];
		else if (dp_q && wr_q && slave_port_ready)
			mem[a_q] <= s_hwdata;
	end
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ns
module testbench
	import dfl_pkg::*;
;
	logic        clock, nrst, slow, m_hwrite, m_hready, m_hresp;
	logic        s_hwrite, slave_port_ready, s_hresp;
	logic        avs_read, avs_write, avs_waitrequest;
	logic [1:0]  m_htrans, s_htrans;
	logic [2:0]  m_hsize, s_hsize;
	logic [3:0]  avs_address, avs_byteenable;
	logic [31:0] m_haddr, m_hwdata, m_hrdata, s_haddr, s_hwdata, s_hrdata;
	logic [31:0] avs_writedata, avs_readdata, d;
	int          err_count, checks_done;

	dfl_bit_manipulation_engine dut_u (.clock, .nrst, .m_haddr, .m_htrans,
		.m_hwrite, .m_hsize, .m_hwdata, .m_hrdata, .m_hready, .m_hresp,
		.s_haddr, .s_htrans, .s_hwrite, .s_hsize, .s_hwdata, .s_hrdata,
		.slave_port_ready, .s_hresp, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
	dfl_slave_model slv_u (.clock, .nrst, .slow, .s_haddr, .s_htrans,
		.s_hwrite, .s_hsize, .s_hwdata, .s_hrdata, .slave_port_ready,
		.s_hresp);

	// ========
	// Helpers
	function automatic logic [31:0] fld(input logic [4:0] b,
		input logic [3:0] w, input logic [18:0] o);
		return {REGION_VAL, 1'b1, b, w, o};
	endfunction
	function automatic logic [31:0] bop(input logic [2:0] c,
		input logic [4:0] b, input logic [19:0] o);
		return {REGION_VAL, c, b, 1'b0, o};
	endfunction
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task ahb(input logic [31:0] a, input logic w, input logic [2:0] z,
		input logic [31:0] wd, output logic [31:0] rd);
		m_haddr <= a;
		m_htrans <= HTRANS_NONSEQ;
		m_hwrite <= w;
		m_hsize <= z;
		do @(posedge clock); while (m_hready !== 1'b1);
		m_htrans <= HTRANS_IDLE;
		m_hwdata <= wd;
		do @(posedge clock); while (m_hready !== 1'b1);
		rd = m_hrdata;
	endtask
	task avr(input logic [3:0] a, output logic [31:0] rd);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		@(posedge clock);
	endtask
	task avw(input logic [3:0] a, input logic [31:0] wd);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= 1'b1;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		@(posedge clock);
	endtask
	task tally_and_finish;
		if (err_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ========
	// Stimulus
	initial clock = 1'b0;
	always #4 clock = ~clock;
	initial begin
		#20000;
		err_count++;
		tally_and_finish;
	end
	initial begin
		{nrst, slow, m_hwrite, avs_read, avs_write} = '0;
		{m_haddr, m_hwdata, avs_writedata, avs_address} = '0;
		m_htrans = HTRANS_IDLE;
		m_hsize = HSIZE_WORD;
		avs_byteenable = 4'hf;
		repeat (3) @(posedge clock);
		nrst <= 1'b1;
		avr(REG_CTRL, d);
		chk("ctrl", d, 32'h1);
		avr(4'hc, d);
		chk("unmapped", d, 32'h0);
		ahb(PERIPH_BASE + 4, 1, HSIZE_WORD, 32'h1234_5678, d);
		ahb(PERIPH_BASE + 8, 1, HSIZE_WORD, 32'hffff_ffff, d);
		ahb(fld(4, 7, 4), 1, HSIZE_WORD, 32'h0000_0ab0, d);
		ahb(PERIPH_BASE + 4, 0, HSIZE_WORD, 0, d);
		chk("insert", d, 32'h1234_5ab8);
		// Field overruns the byte container at bit 6
		ahb(fld(6, 3, 8), 1, HSIZE_BYTE, 32'h0, d);
		ahb(PERIPH_BASE + 8, 0, HSIZE_WORD, 0, d);
		chk("clip", d, 32'hffff_ff3f);
		// Halfword insert in the upper lane; core replicates the operand
		ahb(fld(0, 3, 10), 1, HSIZE_HALF, 32'h0005_0005, d);
		ahb(PERIPH_BASE + 8, 0, HSIZE_WORD, 0, d);
		chk("half insert", d, 32'hfff5_ff3f);
		ahb(bop(OP_SET_CODE, 0, 4), 0, HSIZE_WORD, 0, d);
		chk("set bit", d, 32'h0);
		slow <= 1'b1;
		ahb(bop(OP_CLEAR_CODE, 3, 4), 0, HSIZE_WORD, 0, d);
		chk("clear bit", d, 32'h1);
		slow <= 1'b0;
		ahb(fld(4, 7, 4), 0, HSIZE_WORD, 0, d);
		chk("extract", d, 32'h0000_00ab);
		ahb(PERIPH_BASE + 4, 0, HSIZE_WORD, 0, d);
		chk("after rmw", d, 32'h1234_5ab1);
		avr(REG_COUNT, d);
		chk("count", d, 32'h6);
		avr(REG_STATUS, d);
		chk("status", d, 32'h8);
		avw(REG_COUNT, 32'h0);
		avw(REG_CTRL, 32'h0);
		ahb(fld(4, 7, 4), 1, HSIZE_WORD, 32'h0000_0ab0, d);
		ahb(PERIPH_BASE + 4, 0, HSIZE_WORD, 0, d);
		chk("plain mode", d, 32'h0000_0ab0);
		avr(REG_COUNT, d);
		chk("count clear", d, 32'h0);
		tally_and_finish;
	end
endmodule
